/* File: pcswm_card_model.sv */
// behavioural card in the socket: drives the status and sense pins, watches card cycles
// assumes plain pin levels; an empty socket leaves the sense lines on their pull-ups
module pcswm_card_model (
   input wire logic present_i,
   input wire logic wp_i,
   input wire logic [1:0] vs_i,
   input wire pcswm_pkg::pcswm_card_cyc_t card_cyc_i,
   output pcswm_pkg::pcswm_card_pins_t pins_o,
   output logic answers_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import pcswm_pkg::*;
   // sense lines are pulled up on the board, so an empty socket reads them high
   assign pins_o = '{card_detect: present_i, wp_iois16: present_i & wp_i,
      bvd1_stschg: present_i, bvd2_spkr: present_i, ready_ireq: present_i,
      card_volt_sense_first: ~present_i | vs_i[0],
      card_volt_sense_second: ~present_i | vs_i[1]};
   // the card picks its own I/O cycles from the enables plus io_hit
   assign answers_o = card_cyc_i.io_hit & ~&card_cyc_i.ce_n;
endmodule : pcswm_card_model

/* File: pcswm_consts.svh */
// constants of the socket window mapper: register offsets, field positions, codes
// assumes byte addresses on an 8-bit APB address, 32-bit data, one word per register
//
// Contract
// - five memory windows, each enabled and configured on its own, may overlap in use.
// - each memory window picks common/attribute, width, wait states, write protect, card enable.
// - memory bounds are 4K pages; no memory match below 64K.
// - equal start and stop opens exactly one 4K page.
// - card page is system page plus signed two's complement window offset.
// - address wrap from offset is not detected or blocked.
// - memory hit needs enable and start <= A[23:12] <= stop.
// - window attribute bit clear selects common memory, set selects attribute memory.
// - two byte-granular 16-bit I/O windows with width, zero-wait and 16-bit select.
// - I/O decode spans the full 64K I/O space.
// - I/O hit needs enable, start <= A[15:0] <= stop, and address-enable low.
// - card-type bit switches dual-purpose card pins between memory and I/O meanings.
// - status shows detect, protect, battery, power, ready; changes raise enabled interrupt.
// - sense pins H/H 5V, L/H 3.3V, H/L future, L/L future plus 3.3V.
// - power switch outputs stay undriven until power control bit 4 is set.
// - socket power off drives the future-voltage code on the enable pair.
// - host voltage strap caught at reset release, read-only bit 7; high means 3.3V.
`ifndef PCSWM_CONSTS_SVH
`define PCSWM_CONSTS_SVH

`define PCSWM_OFS_STATUS 8'h00
`define PCSWM_OFS_PWR 8'h04
`define PCSWM_OFS_VSEL 8'h08
`define PCSWM_OFS_GEN 8'h0C
`define PCSWM_OFS_CSC 8'h10
`define PCSWM_OFS_CSC_MASK 8'h14
`define PCSWM_OFS_WIN_EN 8'h18
`define PCSWM_OFS_MW_BASE 8'h40
`define PCSWM_MW_STRIDE 8'h10
`define PCSWM_MW_START 8'h00
`define PCSWM_MW_STOP 8'h04
`define PCSWM_MW_OFFSET 8'h08
`define PCSWM_OFS_IW_BASE 8'hA0
`define PCSWM_IW_STRIDE 8'h08
`define PCSWM_IW_BOUNDS 8'h00
`define PCSWM_IW_CTRL 8'h04

`define PCSWM_PWR_OUT_EN_BIT 4
`define PCSWM_GEN_IO_TYPE_BIT 5
`define PCSWM_VSEL_STRAP_BIT 7
`define PCSWM_WIN_EN_IO_LSB 8
`define PCSWM_MW_BUS16_BIT 15
`define PCSWM_MW_CE_DIS_BIT 14
`define PCSWM_MW_WAIT_LSB 16
`define PCSWM_MW_WP_BIT 14
`define PCSWM_MW_REG_BIT 15

`define PCSWM_VS_5V 2'h0
`define PCSWM_VS_3V3 2'h1
`define PCSWM_VS_XV 2'h2
`define PCSWM_VS_XV_3V3 2'h3
`define PCSWM_VCC_CODE_OFF 2'h2
`define PCSWM_MEM_MIN_PAGE 12'h010

`define PCSWM_NUM_MW 5
`define PCSWM_NUM_IW 2
`define PCSWM_NUM_STS 6

`endif

/* File: pcswm_pkg.sv */
// types of the socket window mapper: bus carriers, window layouts, state
// assumes pcswm_consts.svh for all numbers
`include "pcswm_consts.svh"

package pcswm_pkg;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pcswm_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pcswm_apb_rsp_t;

   // host cycle, sampled synchronously each clock
   typedef struct packed {
      logic [23:0] addr;
      logic mem_req;
      logic io_req;
      logic aen;
      logic wr;
   } pcswm_host_cyc_t;

   // card pins; dual-purpose pins carry both meanings
   typedef struct packed {
      logic card_detect;
      logic wp_iois16;
      logic bvd1_stschg;
      logic bvd2_spkr;
      logic ready_ireq;
      logic card_volt_sense_first;
      logic card_volt_sense_second;
   } pcswm_card_pins_t;

   typedef struct packed {
      logic [25:0] addr;
      logic reg_n;
      logic [1:0] ce_n;
      logic mem_hit;
      logic io_hit;
      logic [2:0] win;
      logic [1:0] wait_st;
      logic bus16;
      logic zws_n;
      logic iocs16_n;
      logic wr_block;
   } pcswm_card_cyc_t;

   typedef struct packed {
      logic [11:0] start;
      logic [11:0] stop;
      logic [13:0] offset;
      logic reg_sel;
      logic wp;
      logic bus16;
      logic ce_dis;
      logic [1:0] wait_st;
   } pcswm_mem_win_t;

   typedef struct packed {
      logic [15:0] start;
      logic [15:0] stop;
      logic bus16;
      logic zws;
      logic cs16_gen;
   } pcswm_io_win_t;

   typedef struct packed {
      pcswm_mem_win_t [`PCSWM_NUM_MW-1:0] mw;
      pcswm_io_win_t [`PCSWM_NUM_IW-1:0] iw;
      logic [`PCSWM_NUM_MW-1:0] mw_en;
      logic [`PCSWM_NUM_IW-1:0] iw_en;
      logic io_type;
      logic [1:0] vcc_code;
      logic pwr_out_en;
      logic [`PCSWM_NUM_STS-1:0] sts_prev;
      logic [`PCSWM_NUM_STS-1:0] csc;
      logic [`PCSWM_NUM_STS-1:0] csc_mask;
      logic host_3v3;
      logic rst_prev;
      pcswm_apb_rsp_t rsp;
      pcswm_card_cyc_t cyc;
      logic [1:0] vcc_pin;
      logic vcc_oe_n;
      logic irq;
      logic ireq;
   } pcswm_state_t;

endpackage : pcswm_pkg

/* File: pcswm_window_map.sv */
// one-socket window mapper: APB registers, memory/I-O window decode, card status,
// voltage sense, power switch control and host voltage strap
// assumes host cycle and card pins already synchronous to core_clk_i
`include "pcswm_consts.svh"

module pcswm_window_map (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire pcswm_pkg::pcswm_apb_req_t apb_req_i,
   output pcswm_pkg::pcswm_apb_rsp_t apb_rsp_o,
   input wire pcswm_pkg::pcswm_host_cyc_t host_cyc_i,
   input wire pcswm_pkg::pcswm_card_pins_t card_pins_i,
   input wire logic host_volt_strap_i,
   output pcswm_pkg::pcswm_card_cyc_t card_cyc_o,
   output logic card_ireq_o,
   output logic [1:0] socket_power_switch_enable_o,
   output logic socket_power_switch_enable_oe_n_o,
   output logic irq_o
);
   import pcswm_pkg::*;

   pcswm_state_t state_q;
   pcswm_state_t state_d;

   function automatic logic [7:0] mw_ofs(input int n, input logic [7:0] sub);
      mw_ofs = 8'(`PCSWM_OFS_MW_BASE + n * `PCSWM_MW_STRIDE) + sub;
   endfunction : mw_ofs

   function automatic logic [7:0] iw_ofs(input int n, input logic [7:0] sub);
      iw_ofs = 8'(`PCSWM_OFS_IW_BASE + n * `PCSWM_IW_STRIDE) + sub;
   endfunction : iw_ofs

   function automatic logic mem_match(input pcswm_mem_win_t w, input logic en,
                                      input logic [11:0] page);
      // below 64K never maps to card memory; equal bounds give one page
      mem_match = en && (page >= `PCSWM_MEM_MIN_PAGE)
                  && (page >= w.start) && (page <= w.stop);
   endfunction : mem_match

   function automatic logic io_match(input pcswm_io_win_t w, input logic en,
                                     input logic [15:0] a);
      io_match = en && (a >= w.start) && (a <= w.stop);
   endfunction : io_match

   function automatic logic [1:0] vs_decode(input logic vs1, input logic vs2);
      case ({vs1, vs2})
         2'b11: vs_decode = `PCSWM_VS_5V;
         2'b01: vs_decode = `PCSWM_VS_3V3;
         2'b10: vs_decode = `PCSWM_VS_XV;
         default: vs_decode = `PCSWM_VS_XV_3V3;
      endcase
   endfunction : vs_decode

   logic [`PCSWM_NUM_STS-1:0] sts_now;
   logic pwr_active;

   always_comb begin
      // status view; write protect and ready only exist for memory cards
      pwr_active = state_q.pwr_out_en && (state_q.vcc_code != `PCSWM_VCC_CODE_OFF);
      sts_now = {pwr_active,
                 card_pins_i.ready_ireq & ~state_q.io_type,
                 card_pins_i.bvd2_spkr & ~state_q.io_type,
                 card_pins_i.bvd1_stschg,
                 card_pins_i.wp_iois16 & ~state_q.io_type,
                 card_pins_i.card_detect};
   end

   always_comb begin
      logic [31:0] rdata;
      logic hit;
      logic wr_en;
      logic [7:0] a;
      logic [11:0] page;
      logic [13:0] card_page;
      logic found;
      logic [`PCSWM_NUM_STS-1:0] w1c;
      rdata = 32'h0000_0000;
      hit = 1'b0;
      wr_en = 1'b0;
      a = apb_req_i.paddr;
      page = host_cyc_i.addr[23:12];
      card_page = 14'h0000;
      found = 1'b0;
      w1c = '0;
      state_d = state_q;

      // read decode, used for both the data word and the error answer
      case (a)
         `PCSWM_OFS_STATUS: begin
            rdata[`PCSWM_NUM_STS-1:0] = sts_now;
            hit = 1'b1;
         end
         `PCSWM_OFS_PWR: begin
            rdata[1:0] = state_q.vcc_code;
            rdata[`PCSWM_PWR_OUT_EN_BIT] = state_q.pwr_out_en;
            hit = 1'b1;
         end
         `PCSWM_OFS_VSEL: begin
            rdata[1:0] = vs_decode(card_pins_i.card_volt_sense_first,
                                   card_pins_i.card_volt_sense_second);
            rdata[`PCSWM_VSEL_STRAP_BIT] = state_q.host_3v3;
            hit = 1'b1;
         end
         `PCSWM_OFS_GEN: begin
            rdata[`PCSWM_GEN_IO_TYPE_BIT] = state_q.io_type;
            hit = 1'b1;
         end
         `PCSWM_OFS_CSC: begin
            rdata[`PCSWM_NUM_STS-1:0] = state_q.csc;
            hit = 1'b1;
         end
         `PCSWM_OFS_CSC_MASK: begin
            rdata[`PCSWM_NUM_STS-1:0] = state_q.csc_mask;
            hit = 1'b1;
         end
         `PCSWM_OFS_WIN_EN: begin
            rdata[`PCSWM_NUM_MW-1:0] = state_q.mw_en;
            rdata[`PCSWM_WIN_EN_IO_LSB +: `PCSWM_NUM_IW] = state_q.iw_en;
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      for (int n = 0; n < `PCSWM_NUM_MW; n++) begin
         if (a == mw_ofs(n, `PCSWM_MW_START)) begin
            rdata[11:0] = state_q.mw[n].start;
            rdata[`PCSWM_MW_CE_DIS_BIT] = state_q.mw[n].ce_dis;
            rdata[`PCSWM_MW_BUS16_BIT] = state_q.mw[n].bus16;
            hit = 1'b1;
         end
         if (a == mw_ofs(n, `PCSWM_MW_STOP)) begin
            rdata[11:0] = state_q.mw[n].stop;
            rdata[`PCSWM_MW_WAIT_LSB +: 2] = state_q.mw[n].wait_st;
            hit = 1'b1;
         end
         if (a == mw_ofs(n, `PCSWM_MW_OFFSET)) begin
            rdata[13:0] = state_q.mw[n].offset;
            rdata[`PCSWM_MW_WP_BIT] = state_q.mw[n].wp;
            rdata[`PCSWM_MW_REG_BIT] = state_q.mw[n].reg_sel;
            hit = 1'b1;
         end
      end
      for (int n = 0; n < `PCSWM_NUM_IW; n++) begin
         if (a == iw_ofs(n, `PCSWM_IW_BOUNDS)) begin
            rdata = {state_q.iw[n].stop, state_q.iw[n].start};
            hit = 1'b1;
         end
         if (a == iw_ofs(n, `PCSWM_IW_CTRL)) begin
            rdata[2:0] = {state_q.iw[n].cs16_gen, state_q.iw[n].zws, state_q.iw[n].bus16};
            hit = 1'b1;
         end
      end

      // zero-wait slave: answer is loaded at the setup edge, done in first access cycle
      state_d.rsp.pready = apb_req_i.psel && !apb_req_i.penable;
      if (apb_req_i.psel && !apb_req_i.penable) begin
         state_d.rsp.prdata = apb_req_i.pwrite ? 32'h0000_0000 : rdata;
         state_d.rsp.pslverr = !hit;
      end
      wr_en = apb_req_i.psel && apb_req_i.penable && state_q.rsp.pready
              && apb_req_i.pwrite && hit;

      if (wr_en) begin
         case (a)
            `PCSWM_OFS_PWR: begin
               state_d.vcc_code = apb_req_i.pwdata[1:0];
               state_d.pwr_out_en = apb_req_i.pwdata[`PCSWM_PWR_OUT_EN_BIT];
            end
            `PCSWM_OFS_GEN: begin
               state_d.io_type = apb_req_i.pwdata[`PCSWM_GEN_IO_TYPE_BIT];
            end
            `PCSWM_OFS_CSC: begin
               w1c = apb_req_i.pwdata[`PCSWM_NUM_STS-1:0];
            end
            `PCSWM_OFS_CSC_MASK: begin
               state_d.csc_mask = apb_req_i.pwdata[`PCSWM_NUM_STS-1:0];
            end
            `PCSWM_OFS_WIN_EN: begin
               state_d.mw_en = apb_req_i.pwdata[`PCSWM_NUM_MW-1:0];
               state_d.iw_en = apb_req_i.pwdata[`PCSWM_WIN_EN_IO_LSB +: `PCSWM_NUM_IW];
            end
            default: begin
               state_d.io_type = state_q.io_type;
            end
         endcase
         for (int n = 0; n < `PCSWM_NUM_MW; n++) begin
            if (a == mw_ofs(n, `PCSWM_MW_START)) begin
               state_d.mw[n].start = apb_req_i.pwdata[11:0];
               state_d.mw[n].ce_dis = apb_req_i.pwdata[`PCSWM_MW_CE_DIS_BIT];
               state_d.mw[n].bus16 = apb_req_i.pwdata[`PCSWM_MW_BUS16_BIT];
            end
            if (a == mw_ofs(n, `PCSWM_MW_STOP)) begin
               state_d.mw[n].stop = apb_req_i.pwdata[11:0];
               state_d.mw[n].wait_st = apb_req_i.pwdata[`PCSWM_MW_WAIT_LSB +: 2];
            end
            if (a == mw_ofs(n, `PCSWM_MW_OFFSET)) begin
               state_d.mw[n].offset = apb_req_i.pwdata[13:0];
               state_d.mw[n].wp = apb_req_i.pwdata[`PCSWM_MW_WP_BIT];
               state_d.mw[n].reg_sel = apb_req_i.pwdata[`PCSWM_MW_REG_BIT];
            end
         end
         for (int n = 0; n < `PCSWM_NUM_IW; n++) begin
            if (a == iw_ofs(n, `PCSWM_IW_BOUNDS)) begin
               state_d.iw[n].start = apb_req_i.pwdata[15:0];
               state_d.iw[n].stop = apb_req_i.pwdata[31:16];
            end
            if (a == iw_ofs(n, `PCSWM_IW_CTRL)) begin
               state_d.iw[n].bus16 = apb_req_i.pwdata[0];
               state_d.iw[n].zws = apb_req_i.pwdata[1];
               state_d.iw[n].cs16_gen = apb_req_i.pwdata[2];
            end
         end
      end

      // change detect; a new change in the clearing cycle survives the clear
      state_d.sts_prev = sts_now;
      state_d.csc = (state_q.csc & ~w1c) | (sts_now ^ state_q.sts_prev);
      state_d.irq = |(state_d.csc & state_d.csc_mask);

      // in I/O mode the ready pin carries the card interrupt request
      state_d.ireq = state_q.io_type & card_pins_i.ready_ireq;

      // switch pins stay released until enabled; off means the future-voltage code
      state_d.vcc_oe_n = !state_q.pwr_out_en;
      state_d.vcc_pin = state_q.pwr_out_en ? state_q.vcc_code : `PCSWM_VCC_CODE_OFF;

      // card cycle; lowest numbered window wins when windows overlap
      state_d.cyc = '0;
      state_d.cyc.reg_n = 1'b1;
      state_d.cyc.ce_n = 2'b11;
      state_d.cyc.zws_n = 1'b1;
      state_d.cyc.iocs16_n = 1'b1;
      if (host_cyc_i.mem_req) begin
         for (int n = `PCSWM_NUM_MW - 1; n >= 0; n--) begin
            if (mem_match(state_q.mw[n], state_q.mw_en[n], page)) begin
               found = 1'b1;
               // offset add wraps silently inside the card space
               card_page = 14'({2'b00, page} + state_q.mw[n].offset);
               state_d.cyc.addr = {card_page, host_cyc_i.addr[11:0]};
               state_d.cyc.reg_n = !state_q.mw[n].reg_sel;
               state_d.cyc.win = 3'(n);
               state_d.cyc.wait_st = state_q.mw[n].wait_st;
               state_d.cyc.bus16 = state_q.mw[n].bus16;
               state_d.cyc.wr_block = host_cyc_i.wr && state_q.mw[n].wp;
               state_d.cyc.ce_n = state_q.mw[n].ce_dis ? 2'b11
                                  : (state_q.mw[n].bus16 ? 2'b00 : 2'b10);
            end
         end
         state_d.cyc.mem_hit = found;
      end else if (host_cyc_i.io_req && !host_cyc_i.aen) begin
         for (int n = `PCSWM_NUM_IW - 1; n >= 0; n--) begin
            if (io_match(state_q.iw[n], state_q.iw_en[n], host_cyc_i.addr[15:0])) begin
               found = 1'b1;
               state_d.cyc.addr = {10'h000, host_cyc_i.addr[15:0]};
               state_d.cyc.reg_n = 1'b0;
               state_d.cyc.win = 3'(n);
               state_d.cyc.bus16 = state_q.iw[n].bus16;
               // the card answers from these enables plus its I/O command
               state_d.cyc.ce_n = state_q.iw[n].bus16 ? 2'b00 : 2'b10;
               state_d.cyc.zws_n = !(state_q.iw[n].zws && !state_q.iw[n].bus16);
               state_d.cyc.iocs16_n = !(state_q.iw[n].bus16 && state_q.iw[n].cs16_gen
                                        && state_q.io_type && card_pins_i.wp_iois16);
            end
         end
         state_d.cyc.io_hit = found;
      end

      // strap is caught at the first edge after reset falls
      state_d.rst_prev = 1'b0;
      if (state_q.rst_prev) begin
         state_d.host_3v3 = host_volt_strap_i;
      end

      if (srst_i) begin
         state_d = '0;
         state_d.rst_prev = 1'b1;
         state_d.vcc_oe_n = 1'b1;
         state_d.vcc_pin = `PCSWM_VCC_CODE_OFF;
         state_d.cyc.reg_n = 1'b1;
         state_d.cyc.ce_n = 2'b11;
         state_d.cyc.zws_n = 1'b1;
         state_d.cyc.iocs16_n = 1'b1;
         state_d.host_3v3 = state_q.host_3v3;
      end
   end

   always_ff @(posedge core_clk_i) begin
      state_q <= state_d;
   end

   assign apb_rsp_o = state_q.rsp;
   assign card_cyc_o = state_q.cyc;
   assign card_ireq_o = state_q.ireq;
   assign socket_power_switch_enable_o = state_q.vcc_pin;
   assign socket_power_switch_enable_oe_n_o = state_q.vcc_oe_n;
   assign irq_o = state_q.irq;

endmodule : pcswm_window_map

/* File: pcswm_window_map_chk.sv */
// assertions on the mapper's ports: APB answer timing, window decode, power pins
// assumes one clock domain and the synchronous reset of the mapper
`include "pcswm_consts.svh"

module pcswm_window_map_chk (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire pcswm_pkg::pcswm_apb_req_t apb_req_i,
   input wire pcswm_pkg::pcswm_apb_rsp_t apb_rsp_o,
   input wire pcswm_pkg::pcswm_host_cyc_t host_cyc_i,
   input wire pcswm_pkg::pcswm_card_pins_t card_pins_i,
   input wire logic host_volt_strap_i,
   input wire pcswm_pkg::pcswm_card_cyc_t card_cyc_o,
   input wire logic card_ireq_o,
   input wire logic [1:0] socket_power_switch_enable_o,
   input wire logic socket_power_switch_enable_oe_n_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import pcswm_pkg::*;
   logic wr_acc;
   assign wr_acc = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);

   a_apb_ready: assert property (apb_req_i.psel && !apb_req_i.penable
      |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready) else $error("pready not one cycle");
   a_low_page_miss: assert property (
      host_cyc_i.mem_req && host_cyc_i.addr[23:12] < `PCSWM_MEM_MIN_PAGE
      |=> !card_cyc_o.mem_hit) else $error("memory hit below 64K");
   a_mem_hit_cause: assert property (
      card_cyc_o.mem_hit |-> $past(host_cyc_i.mem_req)) else $error("memory hit unasked");
   a_io_hit_cause: assert property (card_cyc_o.io_hit |->
      $past(host_cyc_i.io_req && !host_cyc_i.aen)) else $error("io hit on dma or idle");
   a_io_full_addr: assert property (card_cyc_o.io_hit |->
      card_cyc_o.addr == {10'h0, $past(host_cyc_i.addr[15:0])}) else $error("io address");
   a_mem_page_low: assert property (card_cyc_o.mem_hit |->
      card_cyc_o.addr[11:0] == $past(host_cyc_i.addr[11:0])) else $error("page offset");
   a_pwr_off_code: assert property (socket_power_switch_enable_oe_n_o |->
      socket_power_switch_enable_o == `PCSWM_VCC_CODE_OFF) else $error("power code");
   a_pwr_by_write: assert property ($fell(socket_power_switch_enable_oe_n_o) |->
      $past(wr_acc) || $past(wr_acc, 2)) else $error("power enabled without write");
   a_ireq_source: assert property (
      card_ireq_o |-> $past(card_pins_i.ready_ireq)) else $error("ireq without request");
   a_write_block: assert property (card_cyc_o.wr_block |->
      card_cyc_o.mem_hit && $past(host_cyc_i.wr)) else $error("write block on non-write");

   c_mem_hit: cover property (card_cyc_o.mem_hit);
   c_io_hit: cover property (card_cyc_o.io_hit);
   c_irq: cover property ($rose(irq_o));
   c_power: cover property ($fell(socket_power_switch_enable_oe_n_o));
endmodule : pcswm_window_map_chk

bind pcswm_window_map pcswm_window_map_chk chk_u (.core_clk_i(core_clk_i), .srst_i(srst_i),
   .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .host_cyc_i(host_cyc_i),
   .card_pins_i(card_pins_i), .host_volt_strap_i(host_volt_strap_i), .card_cyc_o(card_cyc_o),
   .card_ireq_o(card_ireq_o), .socket_power_switch_enable_o(socket_power_switch_enable_o),
   .socket_power_switch_enable_oe_n_o(socket_power_switch_enable_oe_n_o), .irq_o(irq_o));

/* File: pcswm_window_map_test.sv */
// self-checking bench of the socket window mapper: APB register tasks, host cycle checks
// assumes the card model on the pins and the checker bound to the mapper
`include "pcswm_consts.svh"

module pcswm_window_map_test;
   timeunit 1ns;
   timeprecision 1ps;
   import pcswm_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic strap = 1'b1;
   logic present = 1'b0;
   logic wp = 1'b0;
   logic [1:0] vs = 2'b11;
   logic [1:0] vcc;
   logic oe_n;
   logic ireq;
   logic irq;
   logic ans;
   pcswm_apb_req_t req = '0;
   pcswm_apb_rsp_t rsp;
   pcswm_host_cyc_t hc = '0;
   pcswm_card_pins_t pins;
   pcswm_card_cyc_t cc;
   int miscompares = 0;
   int checks_done = 0;
   // start, stop, offset word of each memory window
   logic [31:0] mwt [15] = '{32'h8010, 32'h30010, 32'hC000, 32'h100, 32'h1FF, 32'h3F00,
      32'h200, 32'h200, 32'h3E10, 32'h0, 32'hF, 32'h0, 32'h1FF, 32'h2FF, 32'h0};
   logic [7:0] zero_regs [4] = '{8'h04, 8'h0C, 8'h14, 8'h18};

   pcswm_window_map dut_u (.core_clk_i(clk), .srst_i(srst), .apb_req_i(req), .apb_rsp_o(rsp),
      .host_cyc_i(hc), .card_pins_i(pins), .host_volt_strap_i(strap), .card_cyc_o(cc),
      .card_ireq_o(ireq), .socket_power_switch_enable_o(vcc),
      .socket_power_switch_enable_oe_n_o(oe_n), .irq_o(irq));
   pcswm_card_model card_u (.present_i(present), .wp_i(wp), .vs_i(vs), .card_cyc_i(cc),
      .pins_o(pins), .answers_o(ans));

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // read data and error are taken at the edge that samples pready high
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] exp, input logic err);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      chk({rsp.pslverr, rsp.prdata}, {err, exp});
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : acc

   function automatic logic [7:0] mwa(input int i);
      return 8'(8'h40 + 16 * (i / 3) + 4 * (i % 3));
   endfunction : mwa

   // hit is {memory, io}; window 0 is attribute, 16-bit, three waits, write protected
   task automatic host(input logic m, input logic io, input logic aen, input logic w,
         input logic [23:0] a, input logic [1:0] hit, input logic [2:0] win,
         input logic [13:0] pg);
      logic [25:0] ca;
      ca = hit[0] ? {10'h0, a[15:0]} : {pg, a[11:0]};
      @(posedge clk);
      hc <= '{addr: a, mem_req: m, io_req: io, aen: aen, wr: w};
      @(posedge clk);
      @(negedge clk);
      if (hit == 2'b00)
         chk({cc.mem_hit, cc.io_hit, ans}, 3'b000);
      else if (hit[0])
         chk({cc.io_hit, cc.win, cc.addr, cc.reg_n, cc.bus16, cc.ce_n, ans},
            {1'b1, win, ca, 1'b0, win[0], ~win[0], 1'b0, 1'b1});
      else
         chk({cc.mem_hit, cc.win, cc.addr, cc.reg_n, cc.bus16, cc.ce_n, cc.wait_st, cc.wr_block},
            {1'b1, win, ca, win != 3'd0, win == 3'd0, win == 3'd0 ? 5'h06 | w : 5'h10});
   endtask : host

   initial forever #4 clk = ~clk;

   initial begin
      repeat (4000) @(posedge clk);
      miscompares++;
      end_sim;
   end

   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      foreach (zero_regs[i]) acc(0, zero_regs[i], 0, 0, 0);
      acc(0, 8'h1C, 0, 0, 1);
      acc(1, 8'h1C, 32'h1, 0, 1);
      acc(1, `PCSWM_OFS_STATUS, 32'h3F, 0, 0);
      acc(0, `PCSWM_OFS_STATUS, 0, 0, 0);
      chk({oe_n, vcc}, 3'b110);
      foreach (mwt[i]) acc(1, mwa(i), mwt[i], 0, 0);
      foreach (mwt[i]) acc(0, mwa(i), 0, mwt[i], 0);
      acc(1, 8'hA0, 32'h0307_0300, 0, 0);
      acc(1, 8'hA8, 32'hFFFF_FF00, 0, 0);
      acc(1, 8'hAC, 32'h1, 0, 0);
      acc(1, `PCSWM_OFS_WIN_EN, 32'h30F, 0, 0);
      host(1, 0, 0, 0, 24'h010ABC, 2'b10, 0, 14'h010);
      host(1, 0, 0, 1, 24'h010004, 2'b10, 0, 14'h010);
      host(1, 0, 0, 0, 24'h011000, 2'b00, 0, 0);
      host(1, 0, 0, 0, 24'h00F000, 2'b00, 0, 0);
      host(1, 0, 0, 0, 24'h100123, 2'b10, 1, 14'h0000);
      host(1, 0, 0, 0, 24'h0FFFFF, 2'b00, 0, 0);
      host(1, 0, 0, 0, 24'h200FFF, 2'b10, 2, 14'h0010);
      host(1, 0, 0, 0, 24'h250000, 2'b00, 0, 0);
      acc(1, `PCSWM_OFS_WIN_EN, 32'h31F, 0, 0);
      host(1, 0, 0, 0, 24'h1FF000, 2'b10, 1, 14'h00FF);
      host(1, 0, 0, 0, 24'h250000, 2'b10, 4, 14'h0250);
      host(0, 1, 0, 0, 24'h000307, 2'b01, 0, 0);
      host(0, 1, 0, 0, 24'h000308, 2'b00, 0, 0);
      host(0, 1, 0, 0, 24'h0002FF, 2'b00, 0, 0);
      host(0, 1, 0, 1, 24'h00FFFF, 2'b01, 1, 0);
      host(0, 1, 1, 0, 24'h000300, 2'b00, 0, 0);
      acc(1, `PCSWM_OFS_CSC_MASK, 32'h3F, 0, 0);
      present <= 1'b1;
      repeat (3) @(posedge clk);
      acc(0, `PCSWM_OFS_STATUS, 0, 32'h1D, 0);
      acc(0, `PCSWM_OFS_CSC, 0, 32'h1D, 0);
      chk(irq, 1'b1);
      acc(1, `PCSWM_OFS_CSC, 32'h1D, 0, 0);
      acc(0, `PCSWM_OFS_CSC, 0, 0, 0);
      chk(irq, 1'b0);
      acc(1, `PCSWM_OFS_CSC_MASK, 32'h1, 0, 0);
      wp <= 1'b1;
      repeat (3) @(posedge clk);
      acc(0, `PCSWM_OFS_CSC, 0, 32'h2, 0);
      chk(irq, 1'b0);
      acc(1, `PCSWM_OFS_CSC, 32'h2, 0, 0);
      acc(1, `PCSWM_OFS_PWR, 32'h11, 0, 0);
      repeat (2) @(negedge clk);
      chk({oe_n, vcc}, 3'b001);
      acc(0, `PCSWM_OFS_STATUS, 0, 32'h3F, 0);
      acc(1, `PCSWM_OFS_PWR, 32'h12, 0, 0);
      repeat (2) @(negedge clk);
      chk({oe_n, vcc}, 3'b010);
      acc(1, `PCSWM_OFS_PWR, 32'h1, 0, 0);
      repeat (2) @(negedge clk);
      chk({oe_n, vcc}, 3'b110);
      chk(ireq, 1'b0);
      acc(1, `PCSWM_OFS_GEN, 32'h20, 0, 0);
      repeat (2) @(negedge clk);
      chk(ireq, 1'b1);
      acc(0, `PCSWM_OFS_STATUS, 0, 32'h5, 0);
      // the strap moves after reset release; the latched level must not follow it
      strap <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         vs <= {~i[1], ~i[0]};
         acc(0, `PCSWM_OFS_VSEL, 0, {24'h0, 1'b1, 5'h0, 2'(i)}, 0);
      end
      // a fresh reset release must latch the strap level standing then
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      acc(0, `PCSWM_OFS_VSEL, 0, 32'h3, 0);
      end_sim;
   end
endmodule : pcswm_window_map_test
